//--- logic/sslc_map.svh
`ifndef SSLC_MAP_SVH
`define SSLC_MAP_SVH

// Word layout
`define SSLC_WORD_W        24
`define SSLC_SEL_LSB       0
`define SSLC_SEL_W         2
// Latch select codes
`define SSLC_SEL_REF       2'h0
`define SSLC_SEL_AB        2'h1
`define SSLC_SEL_FUNC      2'h2
`define SSLC_SEL_INIT      2'h3
// Function latch field positions
`define SSLC_CRST_BIT      2
`define SSLC_PD1_BIT       3
`define SSLC_PD2_BIT       21
// Reset values
`define SSLC_LATCH_RST     24'h000000
// Timing: internal reset pulse length in clock cycles
`define SSLC_PULSE_CYC     4'h2
// Host link limits, informative
`define SSLC_SCLK_MAX_MHZ  20

`endif

//--- logic/sslc_pkg.sv
package sslc_pkg;
  `include "sslc_map.svh"

  typedef logic [`SSLC_WORD_W-1:0] sslc_word_t;

  // Serial pins as one group
  typedef struct packed {
    logic sclk;
    logic data;
    logic strobe;
  } sslc_pins_t;

  // Latch load event
  typedef struct packed {
    logic       valid;
    sslc_word_t word;
  } sslc_load_t;

  typedef enum logic [2:0] {
    SSLC_ST_IDLE  = 3'h1,
    SSLC_ST_SHIFT = 3'h2,
    SSLC_ST_LOAD  = 3'h4
  } sslc_state_t;
endpackage : sslc_pkg

//--- logic/sslc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for the serial pins
module sslc_sync (
  input  wire logic            i_clk,
  input  wire logic            i_reset,
  input  wire logic            i_ce,
  input  wire sslc_pkg::sslc_pins_t i_pins,
  output sslc_pkg::sslc_pins_t o_pins
);
  import sslc_pkg::*;

  sslc_pins_t meta_r;
  sslc_pins_t sync_r;

  // First stage read only by second stage
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (i_ce) begin
      meta_r <= i_pins;
      sync_r <= meta_r;
    end
  end

  assign o_pins = sync_r;
endmodule : sslc_sync

//--- logic/sslc_top.sv
`timescale 1ns/1ps
`include "sslc_map.svh"
// Operation
// - shift one bit per serial clock rise
// - strobe rise copies word to latch
// - low bits 00/01/10 select latches
// - function bit sets/clears counter reset
// - counter reset holds counters, tristates pump
// - code 11 loads function, pulses reset
// - shifting works in every power-down
module sslc_top #(
  parameter int WORD_W    = `SSLC_WORD_W,
  parameter int PULSE_CYC = `SSLC_PULSE_CYC
) (
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  input  wire logic               i_ce,
  input  wire logic               i_sclk,
  input  wire logic               i_data,
  input  wire logic               i_transfer_strobe,
  output sslc_pkg::sslc_word_t    o_ref_latch,
  output sslc_pkg::sslc_word_t    o_ab_latch,
  output sslc_pkg::sslc_word_t    o_func_latch,
  output logic                    o_counter_hold,
  output logic                    o_cp_tristate,
  output logic                    o_sync_pd_arm,
  output logic                    o_load_pulse,
  output logic [1:0]              o_last_sel
);
  import sslc_pkg::*;

  // Refuse sizes the fixed word type and 4-bit pulse counter cannot serve
  if (WORD_W != $bits(sslc_word_t)) begin : g_bad_word
    $error("word width must match the package word type");
  end : g_bad_word
  if (PULSE_CYC < 1 || PULSE_CYC > 15) begin : g_bad_pulse
    $error("reset pulse length must be 1 to 15 cycles");
  end : g_bad_pulse

  // Pin samples, shift register and latch storage
  sslc_pins_t  pins_in;
  sslc_pins_t  pins_s;
  sslc_pins_t  prev_r;
  sslc_word_t  shift_r;
  sslc_word_t  latch_r [3];
  logic [2:0]  ld_vec;
  sslc_word_t  func_cur;
  // Counter reset, pulse and output flops
  logic        crst_r;
  logic        first_ab_r;
  logic [3:0]  pulse_r;
  logic [3:0]  pulse_nxt;
  logic        hold_r;
  logic        tri_r;
  logic        pd_arm_r;
  logic        load_r;
  logic [1:0]  sel_r;
  sslc_state_t state_r;
  sslc_state_t state_nxt;

  assign pins_in.sclk   = i_sclk;
  assign pins_in.data   = i_data;
  assign pins_in.strobe = i_transfer_strobe;

  sslc_sync u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_pins  (pins_in),
    .o_pins  (pins_s)
  );

  // Edge detection and latch decode
  wire         sclk_rise  = pins_s.sclk & ~prev_r.sclk;
  wire         strb_rise  = pins_s.strobe & ~prev_r.strobe;
  wire [1:0]   sel        = shift_r[`SSLC_SEL_LSB +: `SSLC_SEL_W];
  wire         ld_ref     = strb_rise && (sel == `SSLC_SEL_REF);
  wire         ld_ab      = strb_rise && (sel == `SSLC_SEL_AB);
  wire         ld_func    = strb_rise && (sel == `SSLC_SEL_FUNC);
  wire         ld_init    = strb_rise && (sel == `SSLC_SEL_INIT);
  wire         ld_fn_any  = ld_func | ld_init;
  wire         new_crst   = shift_r[`SSLC_CRST_BIT];
  wire         crst_now   = ld_fn_any ? new_crst : crst_r;
  wire         ab_pulse   = ld_ab & first_ab_r;
  wire         pulse_go   = ld_init | ab_pulse;
  wire         pulse_on   = (pulse_nxt != 4'h0);
  wire         func_pd1   = func_cur[`SSLC_PD1_BIT];
  wire         func_pd2   = func_cur[`SSLC_PD2_BIT];

  // Function contents as they stand after this cycle's load
  assign func_cur = ld_fn_any ? shift_r : latch_r[2];
  // Per-latch load strobes, index 0 reference, 1 AB, 2 function
  assign ld_vec   = {ld_fn_any, ld_ab, ld_ref};

  // Internal reset pulse counter
  always_comb begin
    if (pulse_go)
      pulse_nxt = 4'(PULSE_CYC);
    else if (pulse_r != 4'h0)
      pulse_nxt = pulse_r - 4'h1;
    else
      pulse_nxt = 4'h0;
  end

  // Transfer phase; LOAD marks the cycle a latch takes the word
  // A strobe with no new bits still loads the word that stands
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SSLC_ST_IDLE: begin
        if (strb_rise)
          state_nxt = SSLC_ST_LOAD;
        else if (sclk_rise)
          state_nxt = SSLC_ST_SHIFT;
      end
      SSLC_ST_SHIFT: begin
        if (strb_rise)
          state_nxt = SSLC_ST_LOAD;
      end
      SSLC_ST_LOAD: begin
        if (sclk_rise)
          state_nxt = SSLC_ST_SHIFT;
        else
          state_nxt = SSLC_ST_IDLE;
      end
      default:       state_nxt = SSLC_ST_IDLE;
    endcase
  end

  // Pin history and shift register, active in any power-down
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      prev_r  <= '0;
      shift_r <= `SSLC_LATCH_RST;
      state_r <= SSLC_ST_IDLE;
    end else if (i_ce) begin
      prev_r  <= pins_s;
      state_r <= state_nxt;
      if (sclk_rise)
        shift_r <= {shift_r[WORD_W-2:0], pins_s.data};
    end
  end

  // Latch transfers, one flop bank per latch; codes 10 and 11 share the function bank
  for (genvar g = 0; g < 3; g++) begin : g_latch
    always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
        latch_r[g] <= `SSLC_LATCH_RST;
      end else if (i_ce && ld_vec[g]) begin
        latch_r[g] <= shift_r;
      end
    end
  end : g_latch

  // Counter reset level and internal pulse count
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      crst_r  <= 1'b0;
      pulse_r <= 4'h0;
    end else if (i_ce) begin
      crst_r  <= crst_now;
      pulse_r <= pulse_nxt;
    end
  end

  // Only the first AB load after an init load repeats the pulse
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      first_ab_r <= 1'b0;
    end else if (i_ce) begin
      if (ld_init)
        first_ab_r <= 1'b1;
      else if (ld_ab)
        first_ab_r <= 1'b0;
    end
  end

  // Counter hold and pump three-state follow reset level or pulse
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hold_r <= 1'b0;
      tri_r  <= 1'b0;
    end else if (i_ce) begin
      hold_r <= crst_now | pulse_on;
      tri_r  <= crst_now | pulse_on;
    end
  end

  // Counter reset alone never arms synchronous power-down
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pd_arm_r <= 1'b0;
    end else if (i_ce) begin
      pd_arm_r <= pulse_on & func_pd1 & ~func_pd2 & ~crst_now;
    end
  end

  // Load pulse and select code of the last transfer
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      load_r <= 1'b0;
      sel_r  <= 2'h0;
    end else if (i_ce) begin
      load_r <= (state_nxt == SSLC_ST_LOAD);
      if (strb_rise)
        sel_r <= sel;
    end
  end

  assign o_ref_latch    = latch_r[0];
  assign o_ab_latch     = latch_r[1];
  assign o_func_latch   = latch_r[2];
  assign o_counter_hold = hold_r;
  assign o_cp_tristate  = tri_r;
  assign o_sync_pd_arm  = pd_arm_r;
  assign o_load_pulse   = load_r;
  assign o_last_sel     = sel_r;
endmodule : sslc_top

//--- test/sslc_top_properties.sv
`timescale 1ns/1ps
// Output checks for the serial load port
module sslc_top_properties (
  input wire logic                 i_clk,
  input wire logic                 i_reset,
  input wire logic                 i_ce,
  input wire logic                 i_sclk,
  input wire logic                 i_data,
  input wire logic                 i_transfer_strobe,
  input wire sslc_pkg::sslc_word_t o_ref_latch,
  input wire sslc_pkg::sslc_word_t o_ab_latch,
  input wire sslc_pkg::sslc_word_t o_func_latch,
  input wire logic                 o_counter_hold,
  input wire logic                 o_cp_tristate,
  input wire logic                 o_sync_pd_arm,
  input wire logic                 o_load_pulse,
  input wire logic [1:0]           o_last_sel
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Load timing and pulse width
  pulse_once_a: assert property (o_load_pulse && i_ce |=> !o_load_pulse)
    else $error("load pulse too long");
  strobe_load_a: assert property (i_ce && $rose(i_transfer_strobe)
    |-> ##[2:5] o_load_pulse) else $error("strobe gave no load");
  // Counter reset level and its effects
  func_hold_a: assert property (o_load_pulse && o_last_sel == 2'h2
    |-> o_counter_hold == o_func_latch[2]) else $error("hold wrong");
  hold_tri_a: assert property (o_counter_hold == o_cp_tristate)
    else $error("pump state differs from hold");
  no_pd_a: assert property (o_func_latch[2] |-> !o_sync_pd_arm)
    else $error("power-down armed under counter reset");
  init_pulse_a: assert property (o_load_pulse && o_last_sel == 2'h3
    |-> o_counter_hold [*2]) else $error("init pulse missing");
  init_pd_a: assert property (o_load_pulse && o_last_sel == 2'h3
    && o_func_latch[3] && !o_func_latch[21] && !o_func_latch[2]
    |-> o_sync_pd_arm) else $error("init pulse did not arm power-down");
  // Latches change only on their own select code
  ref_keep_a: assert property (!(o_load_pulse && o_last_sel == 2'h0)
    |-> $stable(o_ref_latch)) else $error("ref latch moved");
  ab_keep_a: assert property (!(o_load_pulse && o_last_sel == 2'h1)
    |-> $stable(o_ab_latch)) else $error("ab latch moved");
  func_keep_a: assert property (!(o_load_pulse && o_last_sel[1])
    |-> $stable(o_func_latch)) else $error("function latch moved");
  // Main scenarios reached
  cover property (o_load_pulse && o_last_sel == 2'h3);
  cover property (o_load_pulse && o_last_sel == 2'h1 && o_counter_hold);
  cover property (o_counter_hold && o_func_latch[2]);
  cover property (o_sync_pd_arm && o_load_pulse);
endmodule : sslc_top_properties

bind sslc_top sslc_top_properties i_sslc_top_properties (
  .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_sclk(i_sclk),
  .i_data(i_data), .i_transfer_strobe(i_transfer_strobe),
  .o_ref_latch(o_ref_latch), .o_ab_latch(o_ab_latch),
  .o_func_latch(o_func_latch), .o_counter_hold(o_counter_hold),
  .o_cp_tristate(o_cp_tristate), .o_sync_pd_arm(o_sync_pd_arm),
  .o_load_pulse(o_load_pulse), .o_last_sel(o_last_sel));

//--- test/sslc_host_model.sv
`timescale 1ns/1ps
// Host shifting words into the serial port
module sslc_host_model (
  input  wire logic i_clk,
  output logic      o_sclk,
  output logic      o_data,
  output logic      o_strobe
);
  initial begin
    o_sclk = 1'b0;
    o_data = 1'b0;
    o_strobe = 1'b0;
  end
  // Half of an 800 ns serial period
  task automatic half();
    repeat (4) @(posedge i_clk);
    #10;
  endtask : half
  // Leading filler ones, then the word MSB first
  task automatic send(input logic [23:0] w, input int pre);
    o_strobe = 1'b0;
    for (int i = 23 + pre; i >= 0; i--) begin
      o_data = (i > 23) ? 1'b1 : w[i];
      half();
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
    o_data = ~o_data;
    half();
    o_strobe = 1'b1;
    half();
    o_strobe = 1'b0;
    half(); // Idle gap before the next word
  endtask : send
endmodule : sslc_host_model

//--- test/sslc_top_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the serial load port
module sslc_top_tb;
  import sslc_pkg::*;
  logic       i_clk, i_reset, i_ce, sclk, sdat, stb, hold, pulse;
  logic       pump_off, arm;
  sslc_word_t ref_l, ab_l, fn_l;
  logic [1:0] sel;
  int         err_total, total_checks;
  logic [24:0] rows [9];
  sslc_host_model i_sslc_host_model (.i_clk(i_clk), .o_sclk(sclk),
    .o_data(sdat), .o_strobe(stb));
  sslc_top i_sslc_top (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_sclk(sclk), .i_data(sdat), .i_transfer_strobe(stb),
    .o_ref_latch(ref_l), .o_ab_latch(ab_l), .o_func_latch(fn_l),
    .o_counter_hold(hold), .o_cp_tristate(pump_off), .o_sync_pd_arm(arm),
    .o_load_pulse(pulse), .o_last_sel(sel));
  task automatic chk(input string nm, input logic [23:0] exp, got);
    total_checks++;
    if (got !== exp)
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    if (got !== exp)
      err_total++;
  endtask : chk
  // One word sent, outputs checked in the load cycle
  task automatic load(input sslc_word_t w, input logic h, a, input int pre);
    int n;
    n = 0;
    fork
      i_sslc_host_model.send(w, pre);
      begin
        while (n < 400 && pulse !== 1'b1) begin
          @(negedge i_clk);
          n++;
        end
        chk("pulse", 24'h1, {23'h0, pulse});
        chk("sel", {22'h0, w[1:0]}, {22'h0, sel});
        chk("latch", w, w[1:0] == 2'h0 ? ref_l :
          (w[1:0] == 2'h1 ? ab_l : fn_l));
        chk("hold", {23'h0, h}, {23'h0, hold});
        chk("pump", {23'h0, h}, {23'h0, pump_off});
        chk("arm", {23'h0, a}, {23'h0, arm});
      end
    join
  endtask : load
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    print_verdict();
  end
  // Word beside expected hold: reset method, init, power-down
  initial begin
    rows = '{{24'h000006, 1'b1}, {24'h123454, 1'b1}, {24'habcd05, 1'b1},
      {24'h000002, 1'b0}, {24'h000003, 1'b1}, {24'h00f001, 1'b1},
      {24'h200c0a, 1'b0}, {24'h5a5a58, 1'b0}, {24'h00ff01, 1'b0}};
    err_total = 0;
    total_checks = 0;
    i_ce = 1'b1;
    i_reset = 1'b1;
    repeat (16) @(posedge i_clk);
    #10 i_reset = 1'b0;
    chk("reset", 24'h0, ref_l | ab_l | fn_l | {23'h0, hold});
    foreach (rows[k])
      load(rows[k][24:1], rows[k][0], 1'b0, 0);
    // Frozen by clock enable: a whole word is ignored
    i_ce = 1'b0;
    i_sslc_host_model.send(24'h000006, 0);
    i_ce = 1'b1;
    chk("freeze", 24'h200c0a, fn_l);
    load(24'h00000b, 1'b1, 1'b1, 0);
    load(24'h654321, 1'b1, 1'b1, 4);
    // Second reset in mid-run clears every latch
    i_reset = 1'b1;
    @(posedge i_clk);
    #10 i_reset = 1'b0;
    chk("reset2", 24'h0, ref_l | ab_l | fn_l);
    load(24'h000101, 1'b0, 1'b0, 0);
    print_verdict();
  end
endmodule : sslc_top_tb
